// ---- shared/ppd_pkg.sv ----
// constants and types for the per-port timing drop counters and transmit parse block
package ppd_pkg;

  // ports and bus geometry
  localparam int PPD_NPORT = 3;
  localparam int PPD_AW = 9;
  localparam int PPD_DW = 32;

  // printed register offsets
  localparam logic [8:0] PPD_OFF_TX_PARSE = 9'h158;
  localparam logic [8:0] PPD_OFF_CSUM_CNT = 9'h188;
  localparam logic [8:0] PPD_OFF_FILT_CNT = 9'h18c;
  // bank/port select, unit control and custom destination address
  localparam logic [8:0] PPD_OFF_SEL = 9'h100;
  localparam logic [8:0] PPD_OFF_CTRL = 9'h104;
  localparam logic [8:0] PPD_OFF_MAC_UP = 9'h108;
  localparam logic [8:0] PPD_OFF_MAC_LO = 9'h10c;

  // bank codes
  localparam logic [2:0] PPD_BANK_CNT = 3'h1;
  localparam logic [2:0] PPD_BANK_PARSE = 3'h2;

  // select and control register fields
  localparam int PPD_SEL_BANK_LSB = 0;
  localparam int PPD_SEL_PORT_LSB = 4;
  localparam int PPD_CTRL_ENA_BIT = 0;

  // transmit parse register fields
  localparam int PPD_PARSE_W = 15;
  localparam int PPD_B_V4 = 0;
  localparam int PPD_B_V6 = 1;
  localparam int PPD_B_L2 = 2;
  localparam int PPD_B_MACCHK = 3;
  localparam int PPD_B_IPCHK = 4;
  localparam int PPD_B_V4_CUSTOM = 5;
  localparam int PPD_B_V6_CUSTOM = 6;
  localparam int PPD_B_L2_CUSTOM = 7;
  localparam int PPD_B_GRP0 = 12;
  localparam int PPD_B_L2_GENERAL = 13;
  localparam int PPD_B_L2_PDELAY = 14;
  localparam logic [14:0] PPD_PARSE_RST = 15'h711f;

  // counter width, reset and ceiling
  localparam logic [31:0] PPD_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] PPD_CNT_MAX = 32'hffff_ffff;

  // egress frame format codes
  localparam logic [1:0] PPD_FMT_V4 = 2'h0;
  localparam logic [1:0] PPD_FMT_V6 = 2'h1;
  localparam logic [1:0] PPD_FMT_L2 = 2'h2;

  // fixed destination addresses
  localparam logic [47:0] PPD_MAC_L2_PDELAY = 48'h0180_c200_000e;
  localparam logic [47:0] PPD_MAC_L2_GENERAL = 48'h011b_1900_0000;
  localparam int PPD_NGRP = 5;
  localparam logic [4:0][15:0] PPD_GRP_LO = {16'h006b, 16'h0184, 16'h0183, 16'h0182, 16'h0181};
  localparam logic [4:0] PPD_GRP_ANY_SCOPE = 5'h0f;
  localparam logic [3:0] PPD_V6_FIXED_SCOPE = 4'h2;
  localparam logic [31:0] PPD_V4_MAC_TOP = 32'h0100_5e00;
  localparam logic [31:0] PPD_V6_MAC_TOP = 32'h3333_0000;
  localparam logic [15:0] PPD_V4_IP_TOP = 16'he000;
  localparam logic [7:0] PPD_V6_IP_PFX = 8'hff;

  // state of one saturating counter
  typedef struct packed {
    logic [31:0] count;
  } ppd_cnt_type;

  // state of the register and parse logic
  typedef struct packed {
    logic [2:0] bank;
    logic [1:0] port;
    logic ena;
    logic [15:0] mac_up;
    logic [31:0] mac_lo;
    logic [2:0][14:0] parse;
    logic [31:0] rdata;
    logic [2:0] mac_err;
    logic tx_valid;
    logic tx_hit;
  } ppd_main_type;

endpackage : ppd_pkg

// ---- src/ppd_port_unit.sv ----
// per-port drop counters, transmit parse enables and egress timing classifier
`timescale 1ns/1ps
`default_nettype none
module ppd_port_unit
  import ppd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] rx_csum_drop,
  input wire logic [2:0] rx_filter_drop,
  output logic [2:0] rx_mac_error,
  input wire logic tx_check,
  input wire logic [1:0] tx_port,
  input wire logic [1:0] tx_format,
  input wire logic [47:0] tx_dest_mac,
  input wire logic [127:0] tx_dest_ip,
  output logic tx_result_valid,
  output logic tx_is_timing,
  output logic timing_unit_enable
);

  localparam ppd_main_type PPD_MAIN_RST = '{
    bank: 3'h0,
    port: 2'h0,
    ena: 1'b0,
    mac_up: 16'h0000,
    mac_lo: 32'h0000_0000,
    parse: {PPD_PARSE_RST, PPD_PARSE_RST, PPD_PARSE_RST},
    rdata: 32'h0000_0000,
    mac_err: 3'h0,
    tx_valid: 1'b0,
    tx_hit: 1'b0
  };

  ppd_main_type st_r;
  ppd_main_type st_nxt;

  logic [2:0][31:0] csum_cnt;
  logic [2:0][31:0] filt_cnt;
  logic [2:0] csum_wr;
  logic [2:0] filt_wr;
  logic port_ok;
  logic tx_port_ok;
  logic [14:0] cfg;
  logic [47:0] custom_mac;
  logic [4:0] grp_hit;
  logic mac_pass;
  logic fmt_on;
  logic addr_hit;
  logic l2_hit;
  logic custom_hit;
  logic hit;
  logic [31:0] rd_mux;

  // window target: bank chooses the register set, port its instance
  assign port_ok = st_r.port < 2'(PPD_NPORT);

  // per-port counters and their window-decoded load strobes
  genvar p;
  generate
    for (p = 0; p < PPD_NPORT; p++) begin : g_port
      assign csum_wr[p] = reg_wr && reg_addr == PPD_OFF_CSUM_CNT &&
                          st_r.bank == PPD_BANK_CNT && st_r.port == 2'(p);
      assign filt_wr[p] = reg_wr && reg_addr == PPD_OFF_FILT_CNT &&
                          st_r.bank == PPD_BANK_CNT && st_r.port == 2'(p);
      ppd_sat_counter u_csum (
        .clk_sys(clk_sys),
        .rst(rst),
        .inc(rx_csum_drop[p]),
        .wr(csum_wr[p]),
        .wr_data(reg_wdata),
        .count(csum_cnt[p])
      );
      ppd_sat_counter u_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .inc(rx_filter_drop[p]),
        .wr(filt_wr[p]),
        .wr_data(reg_wdata),
        .count(filt_cnt[p])
      );
    end
  endgenerate

  // configuration of the port whose frame is being classified
  assign tx_port_ok = tx_port < 2'(PPD_NPORT);
  assign cfg = tx_port_ok ? st_r.parse[tx_port] : 15'h0000;
  assign custom_mac = {st_r.mac_up, st_r.mac_lo};
  // with MAC checking off the destination MAC is not examined
  assign mac_pass = !cfg[PPD_B_MACCHK];

  // fixed IP group entries, one per enable bit 12 down to 8
  genvar g;
  generate
    for (g = 0; g < PPD_NGRP; g++) begin : g_grp
      logic mac_ok;
      logic ip_ok;
      logic v6_ip;
      assign v6_ip = tx_dest_ip[127:120] == PPD_V6_IP_PFX &&
                     tx_dest_ip[119:116] == 4'h0 &&
                     (PPD_GRP_ANY_SCOPE[g] || tx_dest_ip[115:112] == PPD_V6_FIXED_SCOPE) &&
                     tx_dest_ip[111:16] == 96'h0 &&
                     tx_dest_ip[15:0] == PPD_GRP_LO[g];
      always_comb begin
        mac_ok = 1'b0;
        ip_ok = 1'b0;
        if (tx_format == PPD_FMT_V4) begin
          mac_ok = tx_dest_mac == {PPD_V4_MAC_TOP, PPD_GRP_LO[g]};
          ip_ok = tx_dest_ip[31:0] == {PPD_V4_IP_TOP, PPD_GRP_LO[g]};
        end else if (tx_format == PPD_FMT_V6) begin
          mac_ok = tx_dest_mac == {PPD_V6_MAC_TOP, PPD_GRP_LO[g]};
          ip_ok = v6_ip;
        end
      end
      assign grp_hit[g] = cfg[PPD_B_GRP0 - g] && (tx_format == PPD_FMT_V4 ||
                          tx_format == PPD_FMT_V6) &&
                          (mac_ok || !cfg[PPD_B_MACCHK]) && (ip_ok || !cfg[PPD_B_IPCHK]);
    end
  endgenerate

  // layer-2 fixed multicast destinations
  assign l2_hit = tx_format == PPD_FMT_L2 &&
                  ((cfg[PPD_B_L2_PDELAY] && (mac_pass || tx_dest_mac == PPD_MAC_L2_PDELAY)) ||
                   (cfg[PPD_B_L2_GENERAL] && (mac_pass || tx_dest_mac == PPD_MAC_L2_GENERAL)));

  // custom destination MAC, enabled separately per format
  always_comb begin
    custom_hit = 1'b0;
    case (tx_format)
      PPD_FMT_L2: custom_hit = cfg[PPD_B_L2_CUSTOM];
      PPD_FMT_V6: custom_hit = cfg[PPD_B_V6_CUSTOM];
      PPD_FMT_V4: custom_hit = cfg[PPD_B_V4_CUSTOM];
      default: custom_hit = 1'b0;
    endcase
    custom_hit = custom_hit && (mac_pass || tx_dest_mac == custom_mac);
  end

  // format detection enable per frame kind
  always_comb begin
    case (tx_format)
      PPD_FMT_V4: fmt_on = cfg[PPD_B_V4];
      PPD_FMT_V6: fmt_on = cfg[PPD_B_V6];
      PPD_FMT_L2: fmt_on = cfg[PPD_B_L2];
      default: fmt_on = 1'b0;
    endcase
  end

  assign addr_hit = (|grp_hit) || l2_hit || custom_hit;
  // only a running unit takes egress timestamps
  assign hit = st_r.ena && tx_port_ok && fmt_on && addr_hit;

  // read multiplexer over the shared window
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      PPD_OFF_SEL: begin
        rd_mux[PPD_SEL_BANK_LSB +: 3] = st_r.bank;
        rd_mux[PPD_SEL_PORT_LSB +: 2] = st_r.port;
      end
      PPD_OFF_CTRL: rd_mux[PPD_CTRL_ENA_BIT] = st_r.ena;
      PPD_OFF_MAC_UP: rd_mux[15:0] = st_r.mac_up;
      PPD_OFF_MAC_LO: rd_mux = st_r.mac_lo;
      PPD_OFF_CSUM_CNT: begin
        if (st_r.bank == PPD_BANK_CNT && port_ok) begin
          rd_mux = csum_cnt[st_r.port];
        end
      end
      PPD_OFF_FILT_CNT: begin
        if (st_r.bank == PPD_BANK_CNT && port_ok) begin
          rd_mux = filt_cnt[st_r.port];
        end
      end
      PPD_OFF_TX_PARSE: begin
        if (st_r.bank == PPD_BANK_PARSE && port_ok) begin
          rd_mux[PPD_PARSE_W-1:0] = st_r.parse[st_r.port];
        end
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next state: register writes, read capture, error and classify results
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = reg_rd ? rd_mux : 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        PPD_OFF_SEL: begin
          st_nxt.bank = reg_wdata[PPD_SEL_BANK_LSB +: 3];
          st_nxt.port = reg_wdata[PPD_SEL_PORT_LSB +: 2];
        end
        PPD_OFF_CTRL: st_nxt.ena = reg_wdata[PPD_CTRL_ENA_BIT];
        PPD_OFF_MAC_UP: st_nxt.mac_up = reg_wdata[15:0];
        PPD_OFF_MAC_LO: st_nxt.mac_lo = reg_wdata;
        PPD_OFF_TX_PARSE: begin
          // software keeps the unit off while changing these
          if (st_r.bank == PPD_BANK_PARSE && port_ok) begin
            st_nxt.parse[st_r.port] = reg_wdata[PPD_PARSE_W-1:0];
          end
        end
        default: st_nxt.bank = st_r.bank;
      endcase
    end
    st_nxt.mac_err = rx_csum_drop | rx_filter_drop;
    st_nxt.tx_valid = tx_check;
    st_nxt.tx_hit = tx_check && hit;
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= PPD_MAIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign rx_mac_error = st_r.mac_err;
  assign tx_result_valid = st_r.tx_valid;
  assign tx_is_timing = st_r.tx_hit;
  assign timing_unit_enable = st_r.ena;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_l2_pdelay_req;
    tx_check && st_r.ena && tx_port_ok && tx_format == PPD_FMT_L2 && cfg[PPD_B_L2] &&
    cfg[PPD_B_L2_PDELAY] && tx_dest_mac == PPD_MAC_L2_PDELAY;
  endsequence

  sequence s_hit_reported;
    tx_result_valid && tx_is_timing;
  endsequence

  property p_err;
    (rx_csum_drop | rx_filter_drop) != 3'h0 |=>
      rx_mac_error == $past(rx_csum_drop | rx_filter_drop);
  endproperty
  a_err: assert property (p_err) else $error("drop not flagged as MAC error");

  property p_rsv;
    reg_rd && reg_addr == PPD_OFF_TX_PARSE |=> reg_rdata[31:15] == 17'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved parse bits not zero");

  property p_cnt_read;
    reg_rd && reg_addr == PPD_OFF_CSUM_CNT && st_r.bank == PPD_BANK_CNT && st_r.port == 2'h0
      |=> reg_rdata == $past(csum_cnt[0]);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("window read wrong counter");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_pdelay;
    s_l2_pdelay_req |=> s_hit_reported;
  endproperty
  a_pdelay: assert property (p_pdelay) else $error("peer delay MAC not classified");

  property p_fmt_off;
    tx_check && !fmt_on |=> tx_result_valid && !tx_is_timing;
  endproperty
  a_fmt_off: assert property (p_fmt_off) else $error("disabled format classified");

  property p_no_check;
    !tx_check |=> !tx_result_valid && !tx_is_timing;
  endproperty
  a_no_check: assert property (p_no_check) else $error("result without request");

  // parse write to port 1, then a read of the same register and port
  sequence s_parse_wr_p1;
    reg_wr && reg_addr == PPD_OFF_TX_PARSE && st_r.bank == PPD_BANK_PARSE && st_r.port == 2'h1;
  endsequence

  sequence s_parse_rd_same;
    reg_rd && reg_addr == PPD_OFF_TX_PARSE && !reg_wr && $stable(st_r.port) &&
    st_r.bank == PPD_BANK_PARSE;
  endsequence

  property p_parse_wr;
    s_parse_wr_p1 ##1 s_parse_rd_same |=> reg_rdata == {17'h0, $past(reg_wdata[14:0], 2)};
  endproperty
  a_parse_wr: assert property (p_parse_wr) else $error("parse write not read back");

endmodule : ppd_port_unit
`default_nettype wire

// ---- src/ppd_sat_counter.sv ----
// saturating 32-bit drop counter with software load
`timescale 1ns/1ps
`default_nettype none
module ppd_sat_counter
  import ppd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inc,
  input wire logic wr,
  input wire logic [31:0] wr_data,
  output logic [31:0] count
);

  ppd_cnt_type st_r;
  ppd_cnt_type st_nxt;

  // software load beats a coincident increment; count stops at the ceiling
  always_comb begin
    st_nxt = st_r;
    if (wr) begin
      st_nxt.count = wr_data;
    end else if (inc && st_r.count != PPD_CNT_MAX) begin
      st_nxt.count = st_r.count + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r.count <= PPD_CNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_sat_hold;
    !wr && count == PPD_CNT_MAX |=> count == PPD_CNT_MAX;
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("counter left its ceiling");

  property p_inc_one;
    !wr && inc && count != PPD_CNT_MAX |=> count == $past(count) + 32'h0000_0001;
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("counter missed an increment");

  // a load followed by one quiet cycle
  sequence s_load_quiet;
    wr ##1 !wr && !inc;
  endsequence

  property p_load;
    s_load_quiet |-> count == $past(wr_data, 1) ##1 count == $past(wr_data, 2);
  endproperty
  a_load: assert property (p_load) else $error("counter did not load write");

  property p_idle;
    !wr && !inc |=> $stable(count);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved without cause");

endmodule : ppd_sat_counter
`default_nettype wire

// ---- tb/ppd_far_side.sv ----
// far side model: switch port frame path raising ingress drop events
`timescale 1ns/1ps
`default_nettype none
module ppd_far_side (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  output logic [2:0] rx_csum_drop,
  output logic [2:0] rx_filter_drop
);
  integer seed = 63100;

  // quiet lines until the first edge
  initial begin
    rx_csum_drop = 3'h0;
    rx_filter_drop = 3'h0;
  end

  // one-cycle drop events per port, both kinds independent, may come every cycle
  always @(posedge clk_sys) begin
    if (rst || !run) begin
      rx_csum_drop <= 3'h0;
      rx_filter_drop <= 3'h0;
    end else begin
      rx_csum_drop <= 3'($random(seed)) & 3'($random(seed));
      rx_filter_drop <= 3'($random(seed)) & 3'($random(seed));
    end
  end
endmodule : ppd_far_side
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the per-port drop counters and egress parse block
`timescale 1ns/1ps
`default_nettype none
module tb_top import ppd_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic [8:0] reg_addr = 9'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] rx_csum_drop, rx_filter_drop, rx_mac_error;
  logic tx_check = 1'b0;
  logic [1:0] tx_port = 2'h0;
  logic [1:0] tx_format = 2'h0;
  logic [47:0] tx_dest_mac = 48'h0;
  logic [127:0] tx_dest_ip = 128'h0;
  logic tx_result_valid, tx_is_timing, timing_unit_enable;
  integer seed = 63100;
  integer n_mismatch = 0;
  integer check_count = 0;
  logic sw_ena = 1'b0;
  logic [31:0] m_cnt [0:1][0:2];
  logic [14:0] m_parse [0:2];
  logic [2:0] m_bank, e_err;
  logic [1:0] m_port;
  logic m_ena, e_v, e_t;
  logic [47:0] m_mac;
  logic [31:0] e_rd;
  logic [15:0] glo [0:4] = '{16'h0181, 16'h0182, 16'h0183, 16'h0184, 16'h006b};
  logic [8:0] amap [0:8] = '{9'h100, 9'h104, 9'h108, 9'h10c, 9'h158, 9'h188, 9'h18c,
    9'h1f0, 9'h15c};

  always #20 clk_sys = ~clk_sys;

  ppd_port_unit ppd_port_unit_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_csum_drop(rx_csum_drop), .rx_filter_drop(rx_filter_drop),
    .rx_mac_error(rx_mac_error), .tx_check(tx_check), .tx_port(tx_port),
    .tx_format(tx_format), .tx_dest_mac(tx_dest_mac), .tx_dest_ip(tx_dest_ip),
    .tx_result_valid(tx_result_valid), .tx_is_timing(tx_is_timing),
    .timing_unit_enable(timing_unit_enable));

  ppd_far_side ppd_far_side_inst (.clk_sys(clk_sys), .rst(rst), .run(run),
    .rx_csum_drop(rx_csum_drop), .rx_filter_drop(rx_filter_drop));

  // expected classification of one egress frame under one port's enables
  function automatic logic timing_exp(input logic [14:0] pc, input logic [1:0] fmt,
    input logic [47:0] mac, input logic [127:0] ip);
    logic hit, mok, iok;
    hit = 1'b0;
    if (fmt == 2'h2 && pc[2]) begin
      hit = (pc[14] && (!pc[3] || mac == 48'h0180_c200_000e))
        || (pc[13] && (!pc[3] || mac == 48'h011b_1900_0000))
        || (pc[7] && (!pc[3] || mac == m_mac));
    end else if ((fmt == 2'h0 && pc[0]) || (fmt == 2'h1 && pc[1])) begin
      hit = pc[fmt[0] ? 6 : 5] && (!pc[3] || mac == m_mac);
      for (int g = 0; g < 5; g++) begin
        mok = mac == (fmt[0] ? {32'h3333_0000, glo[g]} : {32'h0100_5e00, glo[g]});
        iok = fmt[0] ? (ip[127:116] == 12'hff0 && (g < 4 || ip[115:112] == 4'h2)
          && ip[111:0] == {96'h0, glo[g]}) : ip[31:0] == {16'he000, glo[g]};
        hit = hit || (pc[12 - g] && (!pc[3] || mok) && (!pc[4] || iok));
      end
    end
    return hit;
  endfunction : timing_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // reference model: expectations from pre-edge state, then state update
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      m_cnt = '{default: 32'h0};
      m_parse = '{default: 15'h711f};
      m_bank = 3'h0;
      m_port = 2'h0;
      m_ena = 1'b0;
      m_mac = 48'h0;
      e_rd = 32'h0;
      e_err = 3'h0;
      e_v = 1'b0;
      e_t = 1'b0;
    end else begin
      e_rd = 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          9'h100: e_rd = {26'h0, m_port, 1'b0, m_bank};
          9'h104: e_rd = {31'h0, m_ena};
          9'h108: e_rd = {16'h0, m_mac[47:32]};
          9'h10c: e_rd = m_mac[31:0];
          9'h158: if (m_bank == 3'h2 && m_port != 2'h3) e_rd = {17'h0, m_parse[m_port]};
          9'h188: if (m_bank == 3'h1 && m_port != 2'h3) e_rd = m_cnt[0][m_port];
          9'h18c: if (m_bank == 3'h1 && m_port != 2'h3) e_rd = m_cnt[1][m_port];
          default: e_rd = 32'h0;
        endcase
      end
      e_err = rx_csum_drop | rx_filter_drop;
      e_v = tx_check;
      e_t = tx_check && m_ena && tx_port != 2'h3
        && timing_exp(m_parse[tx_port], tx_format, tx_dest_mac, tx_dest_ip);
      for (int k = 0; k < 2; k++) begin
        for (int p = 0; p < 3; p++) begin
          if (reg_wr && m_bank == 3'h1 && m_port == p && reg_addr == (k ? 9'h18c : 9'h188)) begin
            m_cnt[k][p] = reg_wdata;
          end else if ((k ? rx_filter_drop[p] : rx_csum_drop[p])
            && m_cnt[k][p] != 32'hffff_ffff) begin
            m_cnt[k][p] = m_cnt[k][p] + 32'h1;
          end
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          9'h100: {m_port, m_bank} = {reg_wdata[5:4], reg_wdata[2:0]};
          9'h104: m_ena = reg_wdata[0];
          9'h108: m_mac[47:32] = reg_wdata[15:0];
          9'h10c: m_mac[31:0] = reg_wdata;
          9'h158: if (m_bank == 3'h2 && m_port != 2'h3) m_parse[m_port] = reg_wdata[14:0];
          default: m_bank = m_bank;
        endcase
      end
    end
  end

  // every result compared with the model in mid-cycle
  always @(negedge clk_sys) begin
    if (!rst) begin
      chk(reg_rdata, e_rd);
      chk({29'h0, rx_mac_error}, {29'h0, e_err});
      chk({30'h0, tx_result_valid, tx_is_timing}, {30'h0, e_v, e_t});
      chk({31'h0, timing_unit_enable}, {31'h0, m_ena});
    end
  end

  // one bus cycle plus a random egress frame description
  task automatic step(input logic w, input logic r, input logic [8:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic [15:0] lo;
    logic [47:0] mc [0:5];
    logic [127:0] ip;
    @(negedge clk_sys);
    x = $random(seed);
    lo = glo[x[2:0] % 5];
    mc = '{48'h0180_c200_000e, 48'h011b_1900_0000, m_mac, {32'h0100_5e00, lo},
      {32'h3333_0000, lo}, {x, 16'h5a5a}};
    ip = x[6] ? {96'h0, 16'he000, lo} : {12'hff0, x[11] ? 4'h2 : x[10:7], 96'h0, lo};
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    tx_check <= x[17] | x[18];
    tx_port <= x[14:13];
    tx_format <= x[16:15];
    tx_dest_mac <= mc[x[5:3] % 6];
    tx_dest_ip <= x[12] ? {4{$random(seed)}} : ip;
  endtask : step

  // watchdog against a hung run
  initial begin
    #(40 * 20000);
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence: reset values per port, then random register and frame traffic
  initial begin
    logic [31:0] r, d;
    logic [8:0] a;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    run <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      step(1'b1, 1'b0, 9'h100, {26'h0, 2'(p), 4'h2});
      step(1'b0, 1'b1, 9'h158, 32'h0);
      d = $random(seed);
      step(1'b1, 1'b0, 9'h158, d);
      step(1'b0, 1'b1, 9'h158, 32'h0);
    end
    for (int n = 0; n < 6000; n++) begin
      r = $random(seed);
      a = amap[r[7:4] % 9];
      d = $random(seed);
      if (a == 9'h100) d = {26'h0, d[5:4], 2'h0, d[1:0]};
      if ((a == 9'h188 || a == 9'h18c) && r[9]) d = r[8] ? 32'h0 : 32'hffff_fffe;
      if (r[0] && a == 9'h158 && sw_ena) begin
        step(1'b1, 1'b0, 9'h104, 32'h0);
        sw_ena = 1'b0;
      end
      if (r[0] && a == 9'h104) sw_ena = d[0];
      step(r[0], !r[0], a, d);
    end
    run <= 1'b0;
    step(1'b0, 1'b0, 9'h0, 32'h0);
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
